//--- rtl/scac_core.sv
`timescale 1ns/1ns
`include "scac_map.svh"
// Summary of operation
// RQ1: Two-channel emergency stop input for button or door contact.
// RQ2: Emergency stop drops safety outputs, shows red and display code 4.
// RQ3: Emergency stop wins over bypass.
// RQ4: Emergency stop to outputs off within 200 ms.
// RQ5: After power-up, configured stop versus wiring mismatch locks out, code 20.
// RQ6: Stop input drives only this device's own safety outputs.
// RQ7: Bypass shows green and the bypass symbol.
// RQ8: During bypass, field interruptions are ignored.
// RQ9: Bypass requested only by two-level key or two independent signals.
// RQ10: Bypass and presence initiation mode cannot be configured together.
// RQ11: Protection restored within 200 ms after bypass ends.
// RQ12: Status output reports one selectable source of four.
// RQ13: Output-state report: red at once, green after 0.1 to 3.1 s.
// RQ14: Stop selection: status output high while stop pressed.
// RQ15: Object selection: high while object present and blanking selected.
// RQ16: Status output is for signalling only, never for safety.
// RQ17: With conveyor coupling, blanking only while conveyor signal present.
// RQ18: Uncoded, code 1 or code 2; coded receiver accepts own code only.
// RQ19: Neighbouring systems must use different beam codes.
// RQ20: Active beam code shown briefly after power-up.
// RQ21: Range limits depend on resolution: 0.5-6 m or 5-19 m.
// RQ22: Each extra front screen cuts usable range by 8 percent.
// RQ23: Inputs synchronised, debounced; channel disagreement is a fault.
module scac_core #(
  parameter int DEBOUNCE_CYC = `SCAC_DEBOUNCE_US * 1000 / `SCAC_CLK_PERIOD_NS,
  parameter int STEP_CYC     = `SCAC_DELAY_STEP_MS * 1000000 / `SCAC_CLK_PERIOD_NS,
  parameter int STARTUP_CYC  = `SCAC_STARTUP_MS * 1000000 / `SCAC_CLK_PERIOD_NS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        estop_ch_a,
  input  wire logic        estop_ch_b,
  input  wire logic        estop_wired,
  input  wire logic        bypass_ch_a,
  input  wire logic        bypass_ch_b,
  input  wire logic        conveyor_run,
  input  wire logic        field_clear,
  input  wire logic [1:0]  beam_code_rx,
  input  wire logic        object_in_field,
  input  wire logic        screen_dirty,
  input  wire logic        coarse_resolution,
  output logic             safety_switching_output,
  output logic             led_red,
  output logic             led_green,
  output logic      [7:0]  display_code,
  output logic             status_signal_output,
  output logic             blanking_enable,
  output logic             lockout
);

  localparam int NIN = 6;

  // ==========================================
  // Address decode, shared by read and write paths
  function automatic logic [2:0] reg_hit(input logic [11:0] addr);
    reg_hit = {addr == `SCAC_ADDR_STATUS, addr == `SCAC_ADDR_SCAN,
               addr == `SCAC_ADDR_CONFIG};
  endfunction : reg_hit

  scac_pkg::scac_cfg_t   cfg;
  scac_pkg::scac_scan_t  scan;
  scac_pkg::scac_state_t state;
  scac_pkg::scac_state_t next_state;

  // ==========================================
  // Input synchronise and debounce
  // Debounce of 1 ms keeps the stop path far inside its 200 ms budget
  wire logic [NIN-1:0] raw_in = {estop_wired, conveyor_run, bypass_ch_b, bypass_ch_a,
                                 estop_ch_b, estop_ch_a};
  logic [NIN-1:0] sync1;
  logic [NIN-1:0] sync2;
  logic [NIN-1:0] db;
  logic [14:0]    db_cnt [NIN];

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++)
    begin : g_deb
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync1[gi]  <= 1'b0;
          sync2[gi]  <= 1'b0;
          db[gi]     <= 1'b0;
          db_cnt[gi] <= 15'h0000;
        end
        else
        begin
          sync1[gi] <= raw_in[gi]; // RQ23
          sync2[gi] <= sync1[gi];
          if (sync2[gi] == db[gi])
            db_cnt[gi] <= 15'h0000;
          else if (db_cnt[gi] == 15'(DEBOUNCE_CYC - 1))
          begin
            db[gi]     <= sync2[gi]; // RQ23
            db_cnt[gi] <= 15'h0000;
          end
          else
            db_cnt[gi] <= db_cnt[gi] + 15'h0001;
        end
      end
    end
  endgenerate

  // ==========================================
  // Emergency stop, bypass and channel checks
  // Closed contact reads high; either open channel means pressed
  wire logic next_estop   = cfg.estop_en && (!db[0] || !db[1]); // RQ1 RQ4
  wire logic estop_mis    = cfg.estop_en && (db[0] != db[1]);
  wire logic bypass_mis   = cfg.bypass_en && (db[2] != db[3]);
  wire logic all_idle     = (db[0] == db[1]) && !db[2] && !db[3];
  logic      chan_fault;
  wire logic next_fault   = estop_mis || bypass_mis || (chan_fault && !all_idle); // RQ23
  // Both independent channels must request bypass
  wire logic next_bypass  = cfg.bypass_en && db[2] && db[3] && !next_fault; // RQ9

  // ==========================================
  // Beam code, detection and safety output decision
  wire logic beam_ok      = (cfg.beam_code == `SCAC_CODE_NONE) ||
                            (beam_code_rx == cfg.beam_code); // RQ18
  wire logic field_ok     = field_clear && beam_ok;
  // Bypass masks detection only; the stop term is outside the bypass term
  wire logic next_safety_switching_output    = (state == scac_pkg::SCAC_ST_RUN) && !next_estop && !next_fault &&
                            (next_bypass || field_ok); // RQ3 RQ6 RQ8 RQ11
  wire logic next_blank   = cfg.blank_en && (!cfg.conveyor_couple || db[4]); // RQ17

  // ==========================================
  // Start-up window, wiring check and lock-out
  logic [24:0] start_cnt;
  wire logic   start_done = start_cnt == 25'(STARTUP_CYC - 1);
  logic        coarse;

  always_comb
  begin
    next_state = state;
    unique case (state)
      scac_pkg::SCAC_ST_START:
        if (start_done)
          next_state = (cfg.estop_en != db[5]) ? scac_pkg::SCAC_ST_LOCK
                                              : scac_pkg::SCAC_ST_RUN; // RQ5
      scac_pkg::SCAC_ST_RUN:  next_state = scac_pkg::SCAC_ST_RUN;
      scac_pkg::SCAC_ST_LOCK: next_state = scac_pkg::SCAC_ST_LOCK;
      default:                next_state = scac_pkg::SCAC_ST_LOCK;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state     <= scac_pkg::SCAC_ST_START;
      start_cnt <= 25'h0000000;
      coarse    <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == scac_pkg::SCAC_ST_START)
      begin
        start_cnt <= start_done ? start_cnt : start_cnt + 25'h0000001;
        coarse    <= coarse_resolution;
      end
    end
  end

  // ==========================================
  // Display priority
  wire logic [7:0] next_disp =
    (next_state == scac_pkg::SCAC_ST_LOCK) ? `SCAC_DISP_WIRING :    // RQ5
    next_estop                             ? `SCAC_DISP_ESTOP :     // RQ2
    next_bypass                            ? `SCAC_DISP_BYPASS :    // RQ7
    (state == scac_pkg::SCAC_ST_START)     ? (`SCAC_DISP_CODE_BASE | {6'h00, cfg.beam_code}) :
                                             `SCAC_DISP_RUN;        // RQ20

  // ==========================================
  // Green report delay, counted in 0.1 s steps
  logic [21:0] step_cnt;
  logic [4:0]  steps;
  logic        green_done;
  logic        estop_active;
  logic        bypass_active;
  wire logic   step_end = step_cnt == 22'(STEP_CYC - 1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_cnt   <= 22'h000000;
      steps      <= 5'h00;
      green_done <= 1'b0;
    end
    else if (!safety_switching_output)
    begin
      step_cnt   <= 22'h000000; // RQ13
      steps      <= 5'h00;
      green_done <= 1'b0;
    end
    else if (!green_done)
    begin
      step_cnt <= step_end ? 22'h000000 : step_cnt + 22'h000001;
      if (step_end)
      begin
        steps      <= steps + 5'h01;
        green_done <= (steps + 5'h01) == cfg.delay_steps; // RQ13
      end
    end
  end

  wire logic any_blank = cfg.blank_en;
  wire logic next_sso  =
    (cfg.status_sel == `SCAC_SEL_DIRTY) ? screen_dirty :
    (cfg.status_sel == `SCAC_SEL_GREEN) ? (next_safety_switching_output && safety_switching_output && green_done) :
    (cfg.status_sel == `SCAC_SEL_ESTOP) ? next_estop :
                                          (object_in_field && any_blank); // RQ12 RQ14 RQ15

  // ==========================================
  // Registered outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      safety_switching_output <= 1'b0;
      led_red                 <= 1'b1;
      led_green               <= 1'b0;
      display_code            <= `SCAC_DISP_RUN;
      status_signal_output    <= 1'b0;
      blanking_enable         <= 1'b0;
      lockout                 <= 1'b0;
      estop_active            <= 1'b0;
      bypass_active           <= 1'b0;
      chan_fault              <= 1'b0;
    end
    else
    begin
      safety_switching_output <= next_safety_switching_output;   // RQ2
      led_red                 <= !next_safety_switching_output;  // RQ2
      led_green               <= next_safety_switching_output;   // RQ7
      display_code            <= next_disp;
      status_signal_output    <= next_sso;    // RQ12
      blanking_enable         <= next_blank;  // RQ17
      lockout                 <= next_state == scac_pkg::SCAC_ST_LOCK;
      estop_active            <= next_estop;
      bypass_active           <= next_bypass;
      chan_fault              <= next_fault;
    end
  end

  // ==========================================
  // APB slave: one access cycle, errors flagged in setup
  scac_pkg::scac_cfg_t  wcfg;
  scac_pkg::scac_scan_t wscan;
  assign wcfg  = pwdata;
  assign wscan = pwdata;

  wire logic [2:0] hit    = reg_hit(paddr);
  wire logic       setup  = psel && !penable;
  wire logic       cfg_bad = (wcfg.bypass_en && wcfg.presence_initiation_mode) || // RQ10
                             (wcfg.delay_steps == 5'h00) || (wcfg.beam_code == 2'h3);
  wire logic [7:0] rmin   = coarse ? `SCAC_COARSE_MIN_DM : `SCAC_FINE_MIN_DM;
  wire logic [7:0] rmax   = coarse ? `SCAC_COARSE_MAX_DM : `SCAC_FINE_MAX_DM;
  wire logic       scan_bad = (wscan.range_dm < rmin) || (wscan.range_dm > rmax) ||
                              (wscan.screens > `SCAC_MAX_SCREENS); // RQ21
  wire logic       acc_err = !(|hit) || (pwrite && hit[2]) ||
                             (pwrite && hit[0] && cfg_bad) || (pwrite && hit[1] && scan_bad);
  wire logic       wr_do  = psel && penable && pready && pwrite && !pslverr;

  // Usable range after front-screen loss
  wire logic [6:0]  keep_pct = 7'h64 - 7'(`SCAC_SCREEN_PCT * scan.screens);
  // Operands widened first so the product cannot wrap at 8 bits
  wire logic [14:0] prod     = {7'h00, scan.range_dm} * {8'h00, keep_pct};
  wire logic [7:0]  eff_dm   = 8'(prod / 15'h0064); // RQ22

  logic [31:0] status_word;
  always_comb
  begin
    status_word                                 = 32'h0000_0000;
    status_word[`SCAC_ST_SAFE_OUT]              = safety_switching_output;
    status_word[`SCAC_ST_ESTOP]                 = estop_active;
    status_word[`SCAC_ST_BYPASS]                = bypass_active;
    status_word[`SCAC_ST_LOCK]                  = lockout;
    status_word[`SCAC_ST_FAULT]                 = chan_fault;
    status_word[`SCAC_ST_START]                 = state == scac_pkg::SCAC_ST_START;
    status_word[`SCAC_ST_SSO]                   = status_signal_output;
    status_word[`SCAC_ST_DISP_LSB +: 8]         = display_code;
    status_word[`SCAC_ST_RANGE_LSB +: 8]        = eff_dm;
  end

  wire logic [31:0] rd_val = hit[0] ? {14'h0000, cfg[17:0]} :
                             hit[1] ? {22'h000000, scan[9:0]} :
                             hit[2] ? status_word : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      cfg     <= `SCAC_CONFIG_RESET;
      scan    <= `SCAC_SCAN_RESET;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && acc_err;
      prdata  <= (setup && !pwrite) ? rd_val : 32'h0000_0000;
      if (wr_do && hit[0])
        cfg <= {18'h00000, wcfg[13:0]};
      if (wr_do && hit[1])
        scan <= {22'h000000, wscan[9:0]};
    end
  end

  // ==========================================
  // Checks
  estop_drop_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    estop_active |-> !safety_switching_output && led_red)
    else $error("Safety output on during emergency stop");

  estop_disp_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    estop_active && !lockout |-> display_code == `SCAC_DISP_ESTOP)
    else $error("Stop code not shown");

  bypass_green_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
    bypass_active && !estop_active && $past(state) == scac_pkg::SCAC_ST_RUN
    |-> safety_switching_output && display_code == `SCAC_DISP_BYPASS)
    else $error("Bypass did not hold green");

  lock_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    lockout |=> lockout && !safety_switching_output
               && display_code == `SCAC_DISP_WIRING)
    else $error("Lock-out left or output on");

  cfg_excl_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    !(cfg.bypass_en && cfg.presence_initiation_mode))
    else $error("Bypass with presence initiation configured");

  red_fast_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
    cfg.status_sel == `SCAC_SEL_GREEN && $fell(safety_switching_output)
    |=> !status_signal_output)
    else $error("Red not reported at once");

  green_late_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
    cfg.status_sel == `SCAC_SEL_GREEN && $rose(safety_switching_output)
    |=> !status_signal_output [*2])
    else $error("Green reported without delay");

  estop_sso_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
    $stable(cfg) && cfg.status_sel == `SCAC_SEL_ESTOP |=> status_signal_output == estop_active)
    else $error("Status output does not follow stop");

  blank_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
    cfg.conveyor_couple && !db[4] |=> !blanking_enable)
    else $error("Blanking without conveyor signal");

  code_reject_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ18
    cfg.beam_code != `SCAC_CODE_NONE && beam_code_rx != cfg.beam_code && !next_bypass
    |=> !safety_switching_output)
    else $error("Foreign beam code accepted");

endmodule : scac_core

//--- shared/scac_map.svh
`ifndef SCAC_MAP_SVH
`define SCAC_MAP_SVH

// ==========================================
// Register byte addresses
`define SCAC_ADDR_CONFIG     12'h000
`define SCAC_ADDR_SCAN       12'h004
`define SCAC_ADDR_STATUS     12'h008

// ==========================================
// Reset values
`define SCAC_CONFIG_RESET    32'h0000_0200
`define SCAC_SCAN_RESET      32'h0000_0005

// ==========================================
// Status word field positions
`define SCAC_ST_SAFE_OUT     0
`define SCAC_ST_ESTOP        1
`define SCAC_ST_BYPASS       2
`define SCAC_ST_LOCK         3
`define SCAC_ST_FAULT        4
`define SCAC_ST_START        5
`define SCAC_ST_SSO          6
`define SCAC_ST_DISP_LSB     8
`define SCAC_ST_RANGE_LSB    16

// ==========================================
// Status output selections
`define SCAC_SEL_DIRTY       2'h0
`define SCAC_SEL_GREEN       2'h1
`define SCAC_SEL_ESTOP       2'h2
`define SCAC_SEL_OBJECT      2'h3

// ==========================================
// Beam codes
`define SCAC_CODE_NONE       2'h0
`define SCAC_CODE_ONE        2'h1
`define SCAC_CODE_TWO        2'h2

// ==========================================
// Display codes
`define SCAC_DISP_RUN        8'h00
`define SCAC_DISP_ESTOP      8'h04
`define SCAC_DISP_WIRING     8'h20
`define SCAC_DISP_BYPASS     8'h0b
`define SCAC_DISP_CODE_BASE  8'hc0

// ==========================================
// Scanning range limits in decimetres, screen loss in percent
`define SCAC_FINE_MIN_DM     8'h05
`define SCAC_FINE_MAX_DM     8'h3c
`define SCAC_COARSE_MIN_DM   8'h32
`define SCAC_COARSE_MAX_DM   8'hbe
`define SCAC_SCREEN_PCT      7'h08
`define SCAC_MAX_SCREENS     2'h2

// ==========================================
// Timing
`define SCAC_CLK_PERIOD_NS   50
`define SCAC_DEBOUNCE_US     1000
`define SCAC_DELAY_STEP_MS   100
`define SCAC_STARTUP_MS      1000
`define SCAC_ESTOP_RESP_MS   200
`define SCAC_BYPASS_LAT_MS   200

`endif

//--- shared/scac_pkg.sv
package scac_pkg;

  // ==========================================
  // Configuration word
  typedef struct packed {
    logic [17:0] unused;
    logic [4:0]  delay_steps;
    logic [1:0]  beam_code;
    logic [1:0]  status_sel;
    logic        conveyor_couple;
    logic        blank_en;
    logic        presence_initiation_mode;
    logic        bypass_en;
    logic        estop_en;
  } scac_cfg_t;

  // ==========================================
  // Scanning range word
  typedef struct packed {
    logic [21:0] unused;
    logic [1:0]  screens;
    logic [7:0]  range_dm;
  } scac_scan_t;

  // ==========================================
  // Operating states
  typedef enum logic [2:0] {
    SCAC_ST_START = 3'b001,
    SCAC_ST_RUN   = 3'b010,
    SCAC_ST_LOCK  = 3'b100
  } scac_state_t;

endpackage : scac_pkg

//--- verification/scac_partner.sv
`timescale 1ns/1ns
// ==========================================
// Far side: stop switch, bypass key, conveyor contact
module scac_partner (
  input  wire logic pclk,
  input  wire logic estop_press,
  input  wire logic estop_split,
  input  wire logic bypass_req,
  input  wire logic conveyor_on,
  input  wire logic switch_fitted,
  output logic      estop_ch_a,
  output logic      estop_ch_b,
  output logic      estop_wired,
  output logic      bypass_ch_a,
  output logic      bypass_ch_b,
  output logic      conveyor_run
);
  initial
  begin
    estop_ch_a   = 1'b1;
    estop_ch_b   = 1'b1;
    estop_wired  = 1'b1;
    bypass_ch_a  = 1'b0;
    bypass_ch_b  = 1'b0;
    conveyor_run = 1'b0;
  end
  // Contacts open when pressed; split models a welded channel
  always @(posedge pclk)
  begin
    estop_ch_a   <= !estop_press;
    estop_ch_b   <= estop_split | !estop_press;
    estop_wired  <= switch_fitted;
    bypass_ch_a  <= bypass_req;
    bypass_ch_b  <= bypass_req;
    conveyor_run <= conveyor_on;
  end
endmodule : scac_partner

//--- verification/tb_top.sv
`timescale 1ns/1ns
`include "scac_map.svh"
module tb_top;
  // ==========================================
  // Signals
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic e;} scac_row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, ea, eb, ew, ba, bb, cr, ssout, red, green, sso, blank, lock;
  logic [7:0] disp;
  logic estop_press = 1'b0, estop_split = 1'b0, bypass_req = 1'b0, conveyor_on = 1'b0;
  logic switch_fitted = 1'b1, field_clear = 1'b1, object_in_field = 1'b0;
  logic screen_dirty = 1'b0, coarse = 1'b0;
  logic [1:0] beam_code_rx = 2'h1;
  int mismatches = 0, n_checks = 0, n;
  // Stop, bypass, delayed output report, code 1, two delay steps
  localparam logic [31:0] CFG_A = 32'h0000_04a3;
  scac_row_t rows [13] = '{
    '{1'b0, `SCAC_ADDR_SCAN, `SCAC_SCAN_RESET, 1'b0},
    '{1'b1, `SCAC_ADDR_SCAN, 32'h0000_003c, 1'b0},
    '{1'b0, `SCAC_ADDR_SCAN, 32'h0000_003c, 1'b0},
    '{1'b1, `SCAC_ADDR_CONFIG, 32'h0000_0206, 1'b1},
    '{1'b1, `SCAC_ADDR_CONFIG, 32'h0000_0001, 1'b1},
    '{1'b1, `SCAC_ADDR_CONFIG, 32'h0000_0380, 1'b1},
    '{1'b1, `SCAC_ADDR_SCAN, 32'h0000_0004, 1'b1},
    '{1'b1, `SCAC_ADDR_SCAN, 32'h0000_003d, 1'b1},
    '{1'b1, `SCAC_ADDR_SCAN, 32'h0000_0305, 1'b1},
    '{1'b1, `SCAC_ADDR_STATUS, 32'h0000_0000, 1'b1},
    '{1'b1, 12'h010, 32'h0000_0000, 1'b1},
    '{1'b0, 12'h010, 32'h0000_0000, 1'b1},
    '{1'b0, `SCAC_ADDR_CONFIG, CFG_A, 1'b0}};

  always #25 pclk = ~pclk;

  // ==========================================
  // Design and far side
  scac_core #(.DEBOUNCE_CYC(4), .STEP_CYC(8), .STARTUP_CYC(50)) i_scac_core (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .estop_ch_a(ea), .estop_ch_b(eb), .estop_wired(ew), .bypass_ch_a(ba),
    .bypass_ch_b(bb), .conveyor_run(cr), .field_clear(field_clear),
    .beam_code_rx(beam_code_rx), .object_in_field(object_in_field),
    .screen_dirty(screen_dirty), .coarse_resolution(coarse),
    .safety_switching_output(ssout), .led_red(red), .led_green(green),
    .display_code(disp), .status_signal_output(sso), .blanking_enable(blank),
    .lockout(lock));
  scac_partner i_scac_partner (
    .pclk(pclk), .estop_press(estop_press), .estop_split(estop_split),
    .bypass_req(bypass_req), .conveyor_on(conveyor_on), .switch_fitted(switch_fitted),
    .estop_ch_a(ea), .estop_ch_b(eb), .estop_wired(ew), .bypass_ch_a(ba),
    .bypass_ch_b(bb), .conveyor_run(cr));

  // ==========================================
  // Tasks
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask : chk

  function automatic logic sig(input int s);
    case (s)
      0: return ssout;
      1: return sso;
      2: return lock;
      default: return blank;
    endcase
  endfunction : sig

  // Bounded wait; a stuck output ends the run rather than hanging it
  task automatic waitx(input int s, input logic v, output int cnt);
    cnt = 0;
    while (sig(s) !== v)
    begin
      @(negedge pclk);
      cnt++;
      if (cnt > 400)
      begin
        $display("ERROR wait %0d expected %b seen %b", s, v, sig(s));
        mismatches++;
        summarize();
      end
    end
  endtask : waitx

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    k = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      k++;
      if (k > 50)
      begin
        $display("ERROR pready expected 1 seen %b", pready);
        mismatches++;
        summarize();
      end
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk("write error", 32'h0, {31'h0, e});
  endtask : wr

  // ==========================================
  // Sequence
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(negedge pclk);
    chk("start display", {24'h0, `SCAC_DISP_CODE_BASE}, {24'h0, disp});
    chk("reset output", 32'h0, {31'h0, ssout});
    wr(`SCAC_ADDR_CONFIG, CFG_A);
    repeat (6) @(negedge pclk);
    chk("code display", 32'h0000_00c1, {24'h0, disp});
    waitx(0, 1'b1, n);
    chk("lockout", 32'h0, {31'h0, lock});
    $display("test startup done");
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
      chk("pslverr", {31'h0, rows[i].e}, {31'h0, er});
      if (!rows[i].w)
        chk("prdata", rows[i].d, rd);
    end
    $display("test registers done");
    @(posedge pclk) field_clear <= 1'b0;
    waitx(0, 1'b0, n);
    @(negedge pclk);
    chk("status red", 32'h0, {31'h0, sso});
    @(posedge pclk) field_clear <= 1'b1;
    waitx(0, 1'b1, n);
    waitx(1, 1'b1, n);
    chk("green delay ok", 32'h1, {31'h0, n >= 16 && n <= 18});
    @(posedge pclk) beam_code_rx <= 2'h2;
    waitx(0, 1'b0, n);
    @(posedge pclk) beam_code_rx <= 2'h1;
    waitx(0, 1'b1, n);
    $display("test status delay and coding done");
    @(posedge pclk) bypass_req <= 1'b1;
    repeat (12) @(posedge pclk);
    field_clear <= 1'b0;
    repeat (3) @(negedge pclk);
    chk("bypass output", 32'h1, {31'h0, ssout});
    chk("bypass green", 32'h1, {31'h0, green});
    chk("bypass display", {24'h0, `SCAC_DISP_BYPASS}, {24'h0, disp});
    wr(`SCAC_ADDR_CONFIG, 32'h0000_04c3);
    @(posedge pclk) estop_press <= 1'b1;
    waitx(0, 1'b0, n);
    @(negedge pclk);
    chk("stop display", {24'h0, `SCAC_DISP_ESTOP}, {24'h0, disp});
    chk("stop red", 32'h1, {31'h0, red});
    chk("stop status", 32'h1, {31'h0, sso});
    @(posedge pclk) estop_press <= 1'b0;
    bypass_req <= 1'b0;
    repeat (20) @(negedge pclk);
    chk("after bypass", 32'h0, {31'h0, ssout});
    @(posedge pclk) field_clear <= 1'b1;
    waitx(0, 1'b1, n);
    $display("test stop and bypass done");
    wr(`SCAC_ADDR_CONFIG, 32'h0000_04fb);
    repeat (3) @(negedge pclk);
    chk("no conveyor", 32'h0, {31'h0, blank});
    @(posedge pclk) object_in_field <= 1'b1;
    conveyor_on <= 1'b1;
    repeat (3) @(negedge pclk);
    chk("object status", 32'h1, {31'h0, sso});
    waitx(3, 1'b1, n);
    wr(`SCAC_ADDR_CONFIG, 32'h0000_049b);
    @(posedge pclk) screen_dirty <= 1'b1;
    repeat (3) @(negedge pclk);
    chk("dirty status", 32'h1, {31'h0, sso});
    $display("test status sources done");
    @(posedge pclk) estop_split <= 1'b1;
    estop_press <= 1'b1;
    waitx(0, 1'b0, n);
    apb(1'b0, `SCAC_ADDR_STATUS, 32'h0, rd, er);
    chk("channel fault", 32'h1, {31'h0, rd[`SCAC_ST_FAULT]});
    @(posedge pclk) estop_split <= 1'b0;
    estop_press <= 1'b0;
    waitx(0, 1'b1, n);
    wr(`SCAC_ADDR_SCAN, 32'h0000_023c);
    apb(1'b0, `SCAC_ADDR_STATUS, 32'h0, rd, er);
    chk("usable range", 32'h0000_0032, {24'h0, rd[23:16]});
    $display("test fault and range done");
    @(posedge pclk) presetn <= 1'b0;
    coarse <= 1'b1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    waitx(2, 1'b1, n);
    chk("wiring display", {24'h0, `SCAC_DISP_WIRING}, {24'h0, disp});
    chk("locked output", 32'h0, {31'h0, ssout});
    apb(1'b1, `SCAC_ADDR_SCAN, 32'h0000_00be, rd, er);
    chk("coarse max", 32'h0, {31'h0, er});
    apb(1'b1, `SCAC_ADDR_SCAN, 32'h0000_0031, rd, er);
    chk("coarse min", 32'h1, {31'h0, er});
    $display("test wiring lockout done");
    summarize();
  end
endmodule : tb_top
